// ==== serial_flash_status_regs_defines.vh ====
// Constants for the serial flash status register bank
`ifndef SERIAL_FLASH_STATUS_REGS_DEFINES_VH
`define SERIAL_FLASH_STATUS_REGS_DEFINES_VH

// ----------------------------------------------
// Instruction opcodes
// ----------------------------------------------
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_SR_LOW 8'h05
`define CMD_READ_SR_MID 8'h35
`define CMD_READ_SR_HIGH 8'h15
`define CMD_WRITE_SR_LOW 8'h01
`define CMD_WRITE_SR_MID 8'h31
`define CMD_WRITE_SR_HIGH 8'h11
`define CMD_ENTER_QUAD_INSTR 8'h38
`define CMD_EXIT_QUAD_INSTR 8'hff
`define CMD_SUSPEND 8'h75
`define CMD_RESUME 8'h7a
`define CMD_ENTER_4BYTE 8'hb7
`define CMD_EXIT_4BYTE 8'he9

// ----------------------------------------------
// Field positions, low byte
// ----------------------------------------------
`define BIT_BUSY 0
`define BIT_WEL 1
`define BP_LSB 2
`define BP_MSB 6
`define BIT_PROT_LO 7

// ----------------------------------------------
// Field positions, mid byte
// ----------------------------------------------
`define BIT_PROT_HI 0
`define BIT_QE 1
`define BIT_PROG_SUSP 2
`define LOCK_LSB 3
`define LOCK_MSB 5
`define BIT_CMP 6
`define BIT_ERASE_SUSP 7

// ----------------------------------------------
// Field positions, high byte
// ----------------------------------------------
`define BIT_ADDR_CUR 0
`define BIT_ADDR_PWR 1
`define BIT_SCHEME 2
`define DRV_LSB 5
`define DRV_MSB 6
`define BIT_HOLD_RST 7

// ----------------------------------------------
// Reset values and protect modes
// ----------------------------------------------
`define BP_RESET 5'h00
`define LOCK_RESET 3'h0
`define DRV_RESET 2'h0
`define PROT_SOFT 2'h0
`define PROT_HW 2'h1
`define PROT_LOCKDOWN 2'h2
`define PROT_OTP 2'h3

// ----------------------------------------------
// Timing
// ----------------------------------------------
`define CORE_CLK_MHZ 40
`define SR_WRITE_TIME_NS 5000
`define SR_WRITE_CYCLES ((`SR_WRITE_TIME_NS * `CORE_CLK_MHZ) / 1000)

`endif

// ==== pin_sync.v ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 6
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] pins_in,
  output wire [WIDTH-1:0] pins_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage only feeds the second
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign pins_out = sync_q;

endmodule

// ==== spi_byte_shift.v ====
// Serial byte shifter, one or four bits per serial clock edge
`timescale 1ns/10ps
module spi_byte_shift (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire active_in,
  input wire quad_in,
  input wire rise_in,
  input wire fall_in,
  input wire [3:0] lines_in,
  input wire [7:0] tx_byte_in,
  output reg [7:0] rx_byte_out,
  output reg rx_valid_out,
  output wire [3:0] tx_nibble_out
);

  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [2:0] cnt_q;

  // Receive on rising edges; count wraps at each byte
  always @(posedge core_clk_in) begin
    if (!rst_n_in || !active_in) begin
      rx_q <= 8'h00;
      cnt_q <= 3'h0;
      rx_byte_out <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (rise_in) begin
        if (quad_in) begin
          rx_q <= {rx_q[3:0], lines_in};
          cnt_q <= cnt_q + 3'h4;
          rx_valid_out <= (cnt_q == 3'h4);
          rx_byte_out <= {rx_q[3:0], lines_in};
        end else begin
          rx_q <= {rx_q[6:0], lines_in[0]};
          cnt_q <= cnt_q + 3'h1;
          rx_valid_out <= (cnt_q == 3'h7);
          rx_byte_out <= {rx_q[6:0], lines_in[0]};
        end
      end
    end
  end

  // Transmit changes on falling edges; reload at a byte boundary
  always @(posedge core_clk_in) begin
    if (!rst_n_in || !active_in) begin
      tx_q <= 8'h00;
    end else if (fall_in) begin
      if (cnt_q == 3'h0) begin
        tx_q <= tx_byte_in;
      end else if (quad_in) begin
        tx_q <= {tx_q[3:0], 4'h0};
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign tx_nibble_out = quad_in ? tx_q[7:4] : {2'b00, tx_q[7], 1'b0};

endmodule

// ==== serial_flash_status_regs.v ====
// Status and configuration register bank of a serial multi-I/O flash
//
// Behaviour
// - Busy flag reads 1 during program, erase or status write, else 0.
// - Write-enable latch is read-only; while 0 writes, program, erase refused.
// - Five block-protect bits pick the protected region when scheme select is 0.
// - Block-protect bits update only in mode 00, or in mode 01 with write-protect pin high.
// - With scheme 0, chip erase only if low three protect bits match the complement bit.
// - Mode 00 writable after write enable; mode 01 gated by write-protect pin.
// - Mode 10 locks writes until power cycle, which returns mode to 00.
// - Mode 11 locks the status registers permanently.
// - Quad enable turns write-protect and hold pins into data lines.
// - Enter four-wire instruction mode is ignored unless quad enable is 1.
// - In four-wire instruction mode quad enable stays 1 on any write.
// - Three security lock bits default 0, set individually, never clear.
// - Complement bit inverts the meaning of the block-protect bits.
// - Suspend sets erase or program flag; resume or power cycle clears both.
// - Current address width bit reads 0 for three bytes, 1 for four.
// - Power-up width bit used only at init, written by third-byte write.
// - Power-up width 0 starts three-byte mode, 1 starts four-byte mode.
// - Pin function bit picks hold or reset, only while quad enable is 0.
// - Scheme select bit is one-time programmable, never returns to 0.
// - Scheme 0 uses block protect; scheme 1 uses per-unit locks instead.
// - With scheme 1 all volatile unit locks are set at power-up.
// - Two drive bits pick full, three quarter, half or quarter strength.
// - Every status write clears the write-enable latch, even when refused.
`timescale 1ns/10ps
`include "serial_flash_status_regs_defines.vh"
module serial_flash_status_regs #(
  parameter SR_WRITE_CYCLES = `SR_WRITE_CYCLES
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire nv_factory_load_in,
  input wire sclk_in,
  input wire cs_n_in,
  input wire [3:0] io_in,
  input wire array_busy_in,
  input wire array_erase_in,
  input wire array_cmd_done_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_out,
  output reg busy_out,
  output reg wel_out,
  output reg [4:0] block_protect_out,
  output reg complement_out,
  output reg block_protect_active_out,
  output reg chip_erase_ok_out,
  output reg unit_lock_preset_out,
  output reg quad_pins_out,
  output reg hold_active_out,
  output reg pin_reset_out,
  output reg [2:0] security_lock_out,
  output reg erase_suspended_out,
  output reg program_suspended_out,
  output reg suspend_req_out,
  output reg resume_req_out,
  output reg four_byte_mode_out,
  output reg quad_instr_mode_out,
  output reg [1:0] drive_strength_out
);

  // ----------------------------------------------
  // Instruction states
  // ----------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_CMD = 2'b01;
  localparam ST_DATA = 2'b10;

  reg [1:0] state_q;
  reg [7:0] opcode_q;
  reg [7:0] data_q;
  reg have_data_q;
  reg sclk_prev_q;
  reg cs_n_prev_q;
  reg init_pending_q;
  reg [15:0] sr_timer_q;

  // Register bank storage
  reg write_enable_latch_q;
  reg [4:0] block_protect_q;
  reg [1:0] reg_protect_mode_q;
  reg quad_io_enable_q;
  reg [2:0] security_lock_q;
  reg complement_protect_q;
  reg erase_suspended_flag_q;
  reg program_suspended_flag_q;
  reg current_addr_width_q;
  reg poweron_addr_width_q;
  reg protection_scheme_select_q;
  reg [1:0] drive_strength_q;
  reg hold_reset_select_q;
  reg quad_instruction_mode_q;

  wire sclk_s;
  wire cs_n_s;
  wire [3:0] io_s;
  wire [7:0] rx_byte;
  wire rx_valid;
  wire [3:0] tx_nibble;
  reg [7:0] tx_byte;

  // ----------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------
  pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pins_in({sclk_in, cs_n_in, io_in}),
    .pins_out({sclk_s, cs_n_s, io_s})
  );

  // Shared pins act as control inputs only while quad enable is 0
  wire pins_are_ctrl = !quad_io_enable_q;
  wire wp_pin_high = !pins_are_ctrl || io_s[2];
  wire hold_now = pins_are_ctrl && !hold_reset_select_q && !io_s[3] && !cs_n_s;
  wire pin_reset = pins_are_ctrl && hold_reset_select_q && !io_s[3];
  wire selected = !cs_n_s && !pin_reset;
  wire sclk_rise = selected && !hold_now && sclk_s && !sclk_prev_q;
  wire sclk_fall = selected && !hold_now && !sclk_s && sclk_prev_q;
  wire cs_rise = cs_n_s && !cs_n_prev_q;
  wire busy = (sr_timer_q != 16'h0000) || array_busy_in;

  // Status register write permission by protect mode
  wire sr_locked = (reg_protect_mode_q == `PROT_LOCKDOWN) ||
                   (reg_protect_mode_q == `PROT_OTP) ||
                   ((reg_protect_mode_q == `PROT_HW) && !wp_pin_high);
  wire sr_write_ok = write_enable_latch_q && !sr_locked && !busy;

  wire is_sr_write = (opcode_q == `CMD_WRITE_SR_LOW) ||
                     (opcode_q == `CMD_WRITE_SR_MID) ||
                     (opcode_q == `CMD_WRITE_SR_HIGH);
  wire exec = cs_rise && (state_q == ST_DATA);

  // Read-back views of the three bytes; reserved bits read zero
  wire [7:0] sr_low = {reg_protect_mode_q[0], block_protect_q, write_enable_latch_q, busy};
  wire [7:0] sr_mid = {erase_suspended_flag_q, complement_protect_q, security_lock_q,
                       program_suspended_flag_q, quad_io_enable_q, reg_protect_mode_q[1]};
  wire [7:0] sr_high = {hold_reset_select_q, drive_strength_q, 2'b00,
                        protection_scheme_select_q, poweron_addr_width_q, current_addr_width_q};

  spi_byte_shift u_shift (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .active_in(selected),
    .quad_in(quad_instruction_mode_q),
    .rise_in(sclk_rise),
    .fall_in(sclk_fall),
    .lines_in(io_s),
    .tx_byte_in(tx_byte),
    .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid),
    .tx_nibble_out(tx_nibble)
  );

  // Byte returned for the status read instructions
  always @* begin
    tx_byte = 8'h00;
    if (opcode_q == `CMD_READ_SR_LOW) begin
      tx_byte = sr_low;
    end else if (opcode_q == `CMD_READ_SR_MID) begin
      tx_byte = sr_mid;
    end else if (opcode_q == `CMD_READ_SR_HIGH) begin
      tx_byte = sr_high;
    end
  end

  wire is_read = (state_q == ST_DATA) && ((opcode_q == `CMD_READ_SR_LOW) ||
                 (opcode_q == `CMD_READ_SR_MID) || (opcode_q == `CMD_READ_SR_HIGH));

  // ----------------------------------------------
  // Instruction sequencing
  // ----------------------------------------------
  always @(posedge core_clk_in) begin
    if (!rst_n_in || pin_reset) begin
      state_q <= ST_IDLE;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
      have_data_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
      case (state_q)
        ST_IDLE: begin
          have_data_q <= 1'b0;
          if (!cs_n_s) begin
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cs_n_s) begin
            state_q <= ST_IDLE;
          end else if (rx_valid) begin
            opcode_q <= rx_byte;
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cs_n_s) begin
            state_q <= ST_IDLE;
          end else if (rx_valid && !have_data_q) begin
            // Only the first data byte counts
            data_q <= rx_byte;
            have_data_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------
  // Volatile state
  // ----------------------------------------------
  always @(posedge core_clk_in) begin
    if (!rst_n_in || pin_reset) begin
      write_enable_latch_q <= 1'b0;
      quad_instruction_mode_q <= 1'b0;
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      // Power-up width reaches the live width only here
      current_addr_width_q <= nv_factory_load_in ? 1'b0 : poweron_addr_width_q;
      sr_timer_q <= 16'h0000;
      init_pending_q <= 1'b1;
      suspend_req_out <= 1'b0;
      resume_req_out <= 1'b0;
    end else begin
      init_pending_q <= 1'b0;
      suspend_req_out <= 1'b0;
      resume_req_out <= 1'b0;
      if (sr_timer_q != 16'h0000) begin
        sr_timer_q <= sr_timer_q - 16'h0001;
      end
      if (array_cmd_done_in) begin
        write_enable_latch_q <= 1'b0;
      end
      if (exec) begin
        if (opcode_q == `CMD_WRITE_ENABLE && !busy) begin
          write_enable_latch_q <= 1'b1;
        end else if (opcode_q == `CMD_WRITE_DISABLE) begin
          write_enable_latch_q <= 1'b0;
        end else if (is_sr_write) begin
          write_enable_latch_q <= 1'b0;
          if (sr_write_ok && have_data_q) begin
            sr_timer_q <= SR_WRITE_CYCLES[15:0];
          end
        end else if (opcode_q == `CMD_ENTER_QUAD_INSTR && quad_io_enable_q) begin
          quad_instruction_mode_q <= 1'b1;
        end else if (opcode_q == `CMD_EXIT_QUAD_INSTR) begin
          quad_instruction_mode_q <= 1'b0;
        end else if (opcode_q == `CMD_ENTER_4BYTE) begin
          current_addr_width_q <= 1'b1;
        end else if (opcode_q == `CMD_EXIT_4BYTE) begin
          current_addr_width_q <= 1'b0;
        end else if (opcode_q == `CMD_SUSPEND && array_busy_in) begin
          suspend_req_out <= 1'b1;
          erase_suspended_flag_q <= array_erase_in;
          program_suspended_flag_q <= !array_erase_in;
        end else if (opcode_q == `CMD_RESUME) begin
          resume_req_out <= 1'b1;
          erase_suspended_flag_q <= 1'b0;
          program_suspended_flag_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------
  // Non-volatile cells
  // ----------------------------------------------
  // Cells keep their value over resets, mode 10 aside; only the factory load clears them
  wire nv_write = exec && is_sr_write && sr_write_ok && have_data_q;
  always @(posedge core_clk_in) begin
    if (!rst_n_in && nv_factory_load_in) begin
      block_protect_q <= `BP_RESET;
      reg_protect_mode_q <= `PROT_SOFT;
      quad_io_enable_q <= 1'b0;
      security_lock_q <= `LOCK_RESET;
      complement_protect_q <= 1'b0;
      poweron_addr_width_q <= 1'b0;
      protection_scheme_select_q <= 1'b0;
      drive_strength_q <= `DRV_RESET;
      hold_reset_select_q <= 1'b0;
    end else if (!rst_n_in) begin
      // A power cycle releases supply lock-down
      if (reg_protect_mode_q == `PROT_LOCKDOWN) begin
        reg_protect_mode_q <= `PROT_SOFT;
      end
    end else if (nv_write) begin
      if (opcode_q == `CMD_WRITE_SR_LOW) begin
        block_protect_q <= data_q[`BP_MSB:`BP_LSB];
        reg_protect_mode_q[0] <= data_q[`BIT_PROT_LO];
      end else if (opcode_q == `CMD_WRITE_SR_MID) begin
        reg_protect_mode_q[1] <= data_q[`BIT_PROT_HI];
        quad_io_enable_q <= data_q[`BIT_QE] || quad_instruction_mode_q;
        security_lock_q <= security_lock_q | data_q[`LOCK_MSB:`LOCK_LSB];
        complement_protect_q <= data_q[`BIT_CMP];
      end else begin
        poweron_addr_width_q <= data_q[`BIT_ADDR_PWR];
        protection_scheme_select_q <= protection_scheme_select_q | data_q[`BIT_SCHEME];
        drive_strength_q <= data_q[`DRV_MSB:`DRV_LSB];
        hold_reset_select_q <= data_q[`BIT_HOLD_RST];
      end
    end
  end

  // ----------------------------------------------
  // Registered outputs
  // ----------------------------------------------
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
      busy_out <= 1'b0;
      wel_out <= 1'b0;
      block_protect_out <= `BP_RESET;
      complement_out <= 1'b0;
      block_protect_active_out <= 1'b0;
      chip_erase_ok_out <= 1'b0;
      unit_lock_preset_out <= 1'b0;
      quad_pins_out <= 1'b0;
      hold_active_out <= 1'b0;
      pin_reset_out <= 1'b0;
      security_lock_out <= `LOCK_RESET;
      erase_suspended_out <= 1'b0;
      program_suspended_out <= 1'b0;
      four_byte_mode_out <= 1'b0;
      quad_instr_mode_out <= 1'b0;
      drive_strength_out <= `DRV_RESET;
    end else begin
      // Drive the data lines only while a status read is selected and not held
      io_out <= tx_nibble;
      io_oe_out <= (is_read && selected && !hold_now) ?
                   (quad_instruction_mode_q ? 4'hf : 4'h2) : 4'h0;
      busy_out <= busy;
      wel_out <= write_enable_latch_q;
      block_protect_out <= block_protect_q;
      complement_out <= complement_protect_q;
      block_protect_active_out <= !protection_scheme_select_q;
      // Per-unit scheme decides chip erase on its own locks
      chip_erase_ok_out <= write_enable_latch_q && (protection_scheme_select_q ||
                           (block_protect_q[2:0] == 3'h0 && !complement_protect_q) ||
                           (block_protect_q[2:0] == 3'h7 && complement_protect_q));
      unit_lock_preset_out <= init_pending_q && protection_scheme_select_q;
      quad_pins_out <= quad_io_enable_q;
      hold_active_out <= hold_now;
      pin_reset_out <= pin_reset;
      security_lock_out <= security_lock_q;
      erase_suspended_out <= erase_suspended_flag_q;
      program_suspended_out <= program_suspended_flag_q;
      four_byte_mode_out <= current_addr_width_q;
      quad_instr_mode_out <= quad_instruction_mode_q;
      drive_strength_out <= drive_strength_q;
    end
  end

endmodule

// ==== serial_flash_status_regs_assertions.sv ====
// Port-level checks for the status register bank
`timescale 1ns/10ps
module sfsr_checker (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire array_busy_in,
  input wire busy_out,
  input wire [4:0] block_protect_out,
  input wire complement_out,
  input wire block_protect_active_out,
  input wire chip_erase_ok_out,
  input wire unit_lock_preset_out,
  input wire quad_pins_out,
  input wire [2:0] security_lock_out,
  input wire erase_suspended_out,
  input wire program_suspended_out,
  input wire suspend_req_out,
  input wire resume_req_out,
  input wire quad_instr_mode_out
);
  // ----------------------------------------------
  // Helpers
  // ----------------------------------------------
  // Cycles since reset release; scheme output rises only then
  reg [2:0] since_rst_q;
  wire [2:0] since_rst_d = (since_rst_q == 3'h7) ? 3'h7 : since_rst_q + 3'h1;
  wire susp_any = erase_suspended_out | program_suspended_out;
  always @(posedge core_clk_in) begin
    since_rst_q <= rst_n_in ? since_rst_d : 3'h0;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------
  // Assertions
  // ----------------------------------------------
  busy_follow_a: assert property (array_busy_in [*4] |-> busy_out)
    else $error("busy low while array busy");
  erase_gate_a: assert property ((chip_erase_ok_out && block_protect_active_out) |->
    ((block_protect_out[2:0] == 3'h0 && !complement_out) || (block_protect_out[2:0] == 3'h7 && complement_out)))
    else $error("chip erase allowed with wrong protect bits");
  qe_hold_a: assert property (quad_instr_mode_out |-> quad_pins_out)
    else $error("quad enable lost in four-wire mode");
  qpi_entry_a: assert property ($rose(quad_instr_mode_out) |-> $past(quad_pins_out))
    else $error("four-wire mode entered without quad enable");
  susp_set_a: assert property (suspend_req_out |-> ##[0:2] susp_any)
    else $error("suspend flag not set");
  susp_clear_a: assert property (resume_req_out |-> ##[0:2] !susp_any)
    else $error("suspend flags not cleared");
  lock_keep_a: assert property (!(|($past(security_lock_out) & ~security_lock_out)))
    else $error("security lock bit cleared");
  scheme_keep_a: assert property ($rose(block_protect_active_out) |-> since_rst_q < 3'h5)
    else $error("scheme select returned to zero");
  preset_scheme_a: assert property (unit_lock_preset_out |-> !block_protect_active_out)
    else $error("unit lock preset under block protect");
endmodule
bind serial_flash_status_regs sfsr_checker chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .array_busy_in(array_busy_in), .busy_out(busy_out), .block_protect_out(block_protect_out),
  .complement_out(complement_out), .block_protect_active_out(block_protect_active_out),
  .chip_erase_ok_out(chip_erase_ok_out), .unit_lock_preset_out(unit_lock_preset_out),
  .quad_pins_out(quad_pins_out), .security_lock_out(security_lock_out),
  .erase_suspended_out(erase_suspended_out), .program_suspended_out(program_suspended_out),
  .suspend_req_out(suspend_req_out), .resume_req_out(resume_req_out),
  .quad_instr_mode_out(quad_instr_mode_out));

// ==== spi_host_model.sv ====
// Serial host model framing flash instructions on the pins
`timescale 1ns/10ps
module spi_host_model (
  input wire core_clk_in,
  input wire [3:0] io_in,
  output reg sclk_out,
  output reg cs_n_out,
  output reg [3:0] io_out
);
  reg quad_q = 1'b0;
  reg wp_n_q = 1'b1;
  // Idle bus: clock parked low, device deselected
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'hf;
  end
  task cyc(input integer n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // One 200 ns serial clock; read bit taken late for margin
  task bit_io(input [3:0] v, output s);
    begin
      io_out = v;
      cyc(4);
      sclk_out = 1'b1;
      cyc(4);
      s = io_in[1];
      sclk_out = 1'b0;
    end
  endtask
  // Byte MSB first; free io1 toggles, never stale
  task byte_io(input [7:0] b, output [7:0] r);
    integer i;
    reg s;
    begin
      r = 8'h00;
      if (quad_q) begin
        bit_io(b[7:4], s);
        bit_io(b[3:0], s);
      end else begin
        for (i = 7; i >= 0; i = i - 1) begin
          bit_io({1'b1, wp_n_q, ~io_in[1], b[i]}, s);
          r = {r[6:0], s};
        end
      end
    end
  endtask
  // Frame: opcode, optional data or read byte, deselect
  task frame(input [7:0] op, input [7:0] d, input integer nd, output [7:0] r);
    begin
      cs_n_out = 1'b0;
      cyc(4);
      byte_io(op, r);
      if (nd != 0) byte_io(d, r);
      cyc(4);
      cs_n_out = 1'b1;
      io_out[1:0] = ~io_out[1:0];
      cyc(16);
    end
  endtask
endmodule

// ==== test_serial_flash_status_regs.sv ====
// Self-checking bench for the status register bank
`timescale 1ns/10ps
module test_serial_flash_status_regs;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg fact = 1'b1;
  reg abusy = 1'b0;
  reg aerase = 1'b0;
  wire sclk, cs_n, busy, write_enable_latch, prst, bpa, ceok, ulp, qpins, qim, esus, psus, fourb;
  wire [3:0] h_io, d_io, d_oe;
  wire [4:0] bp;
  wire [2:0] lock;
  wire [1:0] drv;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer n_ulp = 0;
  integer i;
  reg [7:0] rv;
  // 40 MHz clock
  always #12.5 core_clk_in = ~core_clk_in;
  // Device drives a line when enabled, else host
  wire [3:0] io_w = (d_oe & d_io) | (~d_oe & h_io);
  // Preset is a one-cycle pulse after a power reset, so count it
  always @(posedge core_clk_in) if (ulp === 1'b1) n_ulp <= n_ulp + 1;
  serial_flash_status_regs #(.SR_WRITE_CYCLES(40)) dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .nv_factory_load_in(fact), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_w), .array_busy_in(abusy),
    .array_erase_in(aerase), .array_cmd_done_in(1'b0), .io_out(d_io), .io_oe_out(d_oe),
    .busy_out(busy), .wel_out(write_enable_latch), .block_protect_out(bp), .complement_out(),
    .block_protect_active_out(bpa), .chip_erase_ok_out(ceok), .unit_lock_preset_out(ulp),
    .quad_pins_out(qpins), .hold_active_out(), .pin_reset_out(prst), .security_lock_out(lock),
    .erase_suspended_out(esus), .program_suspended_out(psus), .suspend_req_out(),
    .resume_req_out(), .four_byte_mode_out(fourb), .quad_instr_mode_out(qim), .drive_strength_out(drv));
  spi_host_model host (.core_clk_in(core_clk_in), .io_in(io_w), .sclk_out(sclk), .cs_n_out(cs_n),
    .io_out(h_io));
  // ----------------------------------------------
  // Tasks
  // ----------------------------------------------
  task print_verdict;
    begin
      $display("mismatches %0d, compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Next write enable would be ignored while busy, so wait it out
  task idle;
    integer k;
    begin
      for (k = 0; busy !== 1'b0; k = k + 1) begin
        if (k == 400) begin
          n_mismatch = n_mismatch + 1;
          $display("[FAIL] busy expected 0 seen %b", busy);
          print_verdict;
        end
        cyc(1);
      end
    end
  endtask
  task cmd(input [7:0] op);
    host.frame(op, 8'h00, 0, rv);
  endtask
  task wr(input [7:0] op, input [7:0] d);
    begin
      cmd(8'h06);
      host.frame(op, d, 1, rv);
      idle;
    end
  endtask
  task rdc(input [7:0] op, input [7:0] e, input string nm);
    begin
      host.frame(op, 8'h00, 1, rv);
      chk(nm, e, rv);
    end
  endtask
  task rst(input f);
    begin
      rst_n_in = 1'b0;
      fact = f;
      cyc(5);
      rst_n_in = 1'b1;
      fact = 1'b0;
      cyc(8);
    end
  endtask
  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    rst(1'b1);
    rdc(8'h05, 8'h00, "low");
    rdc(8'h35, 8'h00, "mid");
    rdc(8'h15, 8'h00, "high");
    chk("bp active", 8'h01, bpa);
    host.frame(8'h01, 8'h1c, 1, rv);
    chk("bp no wel", 8'h00, bp);
    cmd(8'h06);
    rdc(8'h05, 8'h02, "wel");
    chk("erase ok", 8'h01, ceok);
    host.frame(8'h01, 8'h1c, 1, rv);
    chk("busy", 8'h01, busy);
    idle;
    chk("wel clr", 8'h00, write_enable_latch);
    rdc(8'h05, 8'h1c, "bp7");
    cmd(8'h06);
    chk("erase no", 8'h00, ceok);
    wr(8'h31, 8'h40);
    cmd(8'h06);
    chk("erase cmp", 8'h01, ceok);
    cmd(8'h04);
    chk("wel off", 8'h00, write_enable_latch);
    // Every drive code, full strength last; reserved bits set
    for (i = 1; i <= 4; i = i + 1) begin
      wr(8'h11, {1'b0, i[1:0], 5'h18});
      chk("drive", {6'h00, i[1:0]}, drv);
      rdc(8'h15, {1'b0, i[1:0], 5'h00}, "high rsv");
    end
    wr(8'h01, 8'h80);
    host.wp_n_q = 1'b0;
    wr(8'h01, 8'h9c);
    chk("bp wp low", 8'h00, bp);
    chk("wel refused", 8'h00, write_enable_latch);
    host.wp_n_q = 1'b1;
    wr(8'h01, 8'h84);
    chk("bp wp high", 8'h01, bp);
    cmd(8'h38);
    chk("qpi no qe", 8'h00, qim);
    wr(8'h31, 8'h42);
    chk("quad pins", 8'h01, qpins);
    cmd(8'h38);
    chk("qpi", 8'h01, qim);
    host.quad_q = 1'b1;
    wr(8'h31, 8'h40);
    chk("qe kept", 8'h01, qpins);
    cmd(8'hff);
    host.quad_q = 1'b0;
    wr(8'h31, 8'h48);
    chk("qe off", 8'h00, qpins);
    wr(8'h31, 8'h40);
    wr(8'h31, 8'h50);
    rdc(8'h35, 8'h58, "locks");
    // Program then erase suspend, each resumed
    for (i = 0; i < 2; i = i + 1) begin
      abusy = 1'b1;
      aerase = i[0];
      cmd(8'h75);
      rdc(8'h35, i[0] ? 8'hd8 : 8'h5c, "susp");
      cmd(8'h7a);
      chk("resumed", 8'h00, {esus, psus});
      abusy = 1'b0;
    end
    cmd(8'h75);
    chk("susp idle", 8'h00, {esus, psus});
    wr(8'h11, 8'h02);
    chk("width now", 8'h00, fourb);
    wr(8'h01, 8'h04);
    wr(8'h31, 8'h59);
    wr(8'h01, 8'h00);
    chk("lockdown", 8'h01, bp);
    rst(1'b0);
    rdc(8'h35, 8'h58, "mode clr");
    chk("four byte", 8'h01, fourb);
    rdc(8'h15, 8'h03, "width");
    wr(8'h01, 8'h00);
    chk("unlocked", 8'h00, bp);
    wr(8'h11, 8'h06);
    chk("scheme on", 8'h00, bpa);
    wr(8'h11, 8'h82);
    rdc(8'h15, 8'h87, "scheme kept");
    chk("no preset", 8'h00, n_ulp[7:0]);
    rst(1'b0);
    chk("preset", 8'h01, n_ulp[7:0]);
    host.io_out[3] = 1'b0;
    cyc(4);
    chk("pin reset", 8'h01, prst);
    host.io_out[3] = 1'b1;
    wr(8'h01, 8'h80);
    wr(8'h31, 8'h59);
    wr(8'h01, 8'h9c);
    rst(1'b0);
    wr(8'h01, 8'h9c);
    rdc(8'h05, 8'h80, "otp");
    print_verdict;
  end
endmodule
